// File: sector_lock_pkg.sv
/*
 Constants and types for the per-sector lock byte and its serial read.
 Assumes a 16-sector array selected by address bits 19..16.
*/
`default_nettype none
package sector_lock_pkg;
   // ==========================================================
   // Array geometry.
   localparam int NUM_SECTORS = 16;
   localparam int SEC_W = 4;
   localparam int SEC_LO = 16;
   typedef logic [SEC_W-1:0] sector_t;
   localparam sector_t SUBSEC_FIRST = 4'h0;
   localparam sector_t SUBSEC_LAST = 4'hf;

   // ==========================================================
   // Lock byte layout.
   localparam int WL_BIT = 0;
   localparam int LD_BIT = 1;
   localparam int SWL_BIT = 2;
   localparam int SLD_BIT = 3;
   typedef logic [3:0] lock_nib_t;
   typedef lock_nib_t [NUM_SECTORS-1:0] lock_vec_t;
   localparam lock_nib_t LOCK_RESET = 4'h0;
   localparam logic [7:0] BYTE_ZERO = 8'h00;
   localparam logic [2:0] BIT_MSB = 3'h7;

   // ==========================================================
   // Serial framing: one command byte plus three address bytes.
   typedef logic [5:0] cnt_t;
   localparam cnt_t HDR_BITS = 6'h20;
   localparam cnt_t HDR_LAST = 6'h1f;
   localparam cnt_t CNT_END = 6'h27;
   localparam cnt_t CNT_ONE = 6'h01;
   localparam int CMD_HI = 31;
   localparam int CMD_LO = 24;
endpackage : sector_lock_pkg
`default_nettype wire

// File: lock_if.sv
/*
 Carrier between the top and the lock store: write port, protection
 query and the live lock array.
 Assumes all members belong to the system clock domain.
*/
`timescale 1ns/1ps
`default_nettype none
interface lock_if;
   import sector_lock_pkg::*;
   logic wr_en; // One-cycle lock write request.
   sector_t wr_sector; // Sector addressed by the write.
   logic [7:0] wr_data; // New lock byte.
   sector_t op_sector; // Sector an array operation aims at.
   logic op_allowed; // Registered permission for that sector.
   lock_vec_t locks; // Live lock bits of every sector.
   modport store (input wr_en, wr_sector, wr_data, op_sector,
                  output op_allowed, locks);
   modport user (output wr_en, wr_sector, wr_data, op_sector,
                 input op_allowed, locks);
endinterface : lock_if
`default_nettype wire

// File: lock_store.sv
/*
 Volatile lock bits of every sector, their guarded update and the
 write/program/erase permission check.
 Assumes a synchronised active-low reset and a clock enable.
*/
`timescale 1ns/1ps
`default_nettype none
module lock_store #(
   parameter bit LEGACY = 1'b0
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic ce,
   lock_if.store lk
);
   import sector_lock_pkg::*;

   lock_vec_t lock_reg; // Stored lock bits.
   lock_vec_t lock_next;
   logic allowed_reg; // Permission answer.
   logic allowed_next;
   lock_nib_t cur; // Lock bits of the written sector.

   // ==========================================================
   // Next-state: a set lock-down bit freezes the sector's write-lock and lock-down bits.
   always_comb begin
      lock_next = lock_reg;
      cur = lock_reg[lk.wr_sector];
      if (lk.wr_en) begin
         if (!cur[LD_BIT]) begin
            lock_next[lk.wr_sector][WL_BIT] = lk.wr_data[WL_BIT];
            lock_next[lk.wr_sector][LD_BIT] = lk.wr_data[LD_BIT];
         end
         // Subsector bits exist only on the legacy option.
         if (LEGACY && !cur[SLD_BIT]) begin
            lock_next[lk.wr_sector][SLD_BIT] = lk.wr_data[SLD_BIT];
            if (lk.wr_sector == SUBSEC_FIRST ||
                lk.wr_sector == SUBSEC_LAST) begin
               lock_next[lk.wr_sector][SWL_BIT] = lk.wr_data[SWL_BIT];
            end
         end
      end
      // A set write lock bars any array change in the sector.
      allowed_next = !lock_reg[lk.op_sector][WL_BIT] &&
                     !lock_reg[lk.op_sector][SWL_BIT];
   end

   // ==========================================================
   // Registers; reset is the only way out of lock-down.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         lock_reg <= '{default: LOCK_RESET};
         allowed_reg <= 1'b0;
      end else if (ce) begin
         lock_reg <= lock_next;
         allowed_reg <= allowed_next;
      end
   end

   assign lk.locks = lock_reg;
   assign lk.op_allowed = allowed_reg;

   // ==========================================================
   // Helper copies of the last write for the checks below.
   logic chk_wr;
   sector_t chk_sec;
   lock_nib_t chk_old;
   logic [1:0] chk_dat;
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         chk_wr <= 1'b0;
         chk_sec <= SUBSEC_FIRST;
         chk_old <= LOCK_RESET;
         chk_dat <= 2'h0;
      end else begin
         chk_wr <= lk.wr_en && ce;
         chk_sec <= lk.wr_sector;
         chk_old <= lock_reg[lk.wr_sector];
         chk_dat <= lk.wr_data[1:0];
      end
   end

   AST_LOCKDOWN_FREEZES: assert property (
      @(posedge clk) disable iff (!rst_n)
      chk_wr && chk_old[LD_BIT] |->
         lock_reg[chk_sec][1:0] == chk_old[1:0])
      else $error("Locked-down sector bits changed.");
   AST_UNLOCKED_UPDATES: assert property (
      @(posedge clk) disable iff (!rst_n)
      chk_wr && !chk_old[LD_BIT] |-> lock_reg[chk_sec][1:0] == chk_dat)
      else $error("Unlocked sector did not take new bits.");
   AST_WRITE_LOCK_BARS: assert property (
      @(posedge clk) disable iff (!rst_n)
      ce ##1 1'b1 |->
         allowed_reg == !($past(lock_reg[lk.op_sector][WL_BIT]) ||
                          $past(lock_reg[lk.op_sector][SWL_BIT])))
      else $error("Permission disagrees with write lock.");
   AST_RESET_CLEARS: assert property (
      @(posedge clk) $rose(rst_n) |-> lock_reg == '0)
      else $error("Lock bits not clear after reset.");
   // The read path masks the bit as well, so only a check on the
   // store or the unmasked permission answer shows a subsector lock landing in a middle sector.
   AST_SUBSEC_STORE: assert property (
      @(posedge clk) disable iff (!rst_n)
      chk_wr && chk_sec != SUBSEC_FIRST && chk_sec != SUBSEC_LAST |->
         !lock_reg[chk_sec][SWL_BIT])
      else $error("Subsector write lock stored for a middle sector.");
endmodule : lock_store
`default_nettype wire

// File: sector_lock_top.sv
/*
 Lock-byte read over the serial link plus the per-sector lock store.
 Assumes a serial clock that runs only inside frames, with select low.
 The link logic is reset by the frame's own select line.
*/
//
// Contract
// - Input bits sampled on serial clock rise.
// - Lock byte shifted out on falling edges.
// - Select high ends read; output released.
// - Read refused while array cycle runs.
// - Set lock-down freezes both sector lock bits.
// - Clear lock-down lets lock bits update.
// - Set write lock blocks array changes.
// - Clear write lock lets array changes proceed.
// - Reset clears every sector's lock bits.
// - Legacy subsector bits; write lock sectors 0,15.
`timescale 1ns/1ps
`default_nettype none
module sector_lock_top #(
   parameter logic [7:0] READ_LOCK_CMD = 8'ha5,
   parameter bit LEGACY = 1'b0
) (
   input wire logic clk,
   input wire logic rstn,
   input wire logic ce,
   input wire logic spi_clk,
   input wire logic select_n,
   input wire logic serial_in_pin,
   output logic serial_out_pin,
   output logic serial_out_oe_n,
   input wire logic busy,
   input wire logic lock_wr_en,
   input wire sector_lock_pkg::sector_t lock_wr_sector,
   input wire logic [7:0] lock_wr_data,
   input wire sector_lock_pkg::sector_t op_sector,
   output logic op_allowed
);
   import sector_lock_pkg::*;

   // ==========================================================
   // Reset release through two flip-flops.
   logic rst_meta;
   logic rst_n;
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         rst_meta <= 1'b0;
         rst_n <= 1'b0;
      end else begin
         rst_meta <= 1'b1;
         rst_n <= rst_meta;
      end
   end

   // ==========================================================
   // Lock store on the system clock.
   lock_if lk ();
   assign lk.wr_en = lock_wr_en;
   assign lk.wr_sector = lock_wr_sector;
   assign lk.wr_data = lock_wr_data;
   assign lk.op_sector = op_sector;
   assign op_allowed = lk.op_allowed;

   lock_store #(.LEGACY(LEGACY)) u_store (
      .clk(clk),
      .rst_n(rst_n),
      .ce(ce),
      .lk(lk)
   );

   // ==========================================================
   // Snapshot for the link domain. It follows the store only while
   // the device is deselected and is frozen during a frame, so the
   // link reads a quiet bus. The freeze lags select by two clocks,
   // far less than the 32 serial edges before it is first read.
   logic sel_meta; // First synchroniser stage, read by sel_sync only.
   logic sel_sync; // Select, high means idle.
   lock_vec_t snap_reg; // Frozen lock array.
   lock_vec_t snap_next;
   logic busy_snap; // Array cycle running at frame start.
   logic busy_snap_next;

   // Follow the store while idle, hold while selected.
   always_comb begin
      snap_next = snap_reg;
      busy_snap_next = busy_snap;
      if (sel_sync) begin
         snap_next = lk.locks;
         busy_snap_next = busy;
      end
   end

   // Register the snapshot and the select synchroniser.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         sel_meta <= 1'b1;
         sel_sync <= 1'b1;
         snap_reg <= '{default: LOCK_RESET};
         busy_snap <= 1'b0;
      end else if (ce) begin
         sel_meta <= select_n;
         sel_sync <= sel_meta;
         snap_reg <= snap_next;
         busy_snap <= busy_snap_next;
      end
   end

   // ==========================================================
   // Link receive side, on rising serial clock edges.
   cnt_t cnt_reg; // Rising edges seen in this frame; wraps from 39 back to 32 after the header.
   cnt_t cnt_next;
   logic [31:0] shift_reg; // Command and address.
   logic [31:0] shift_next;
   logic reading_reg; // Accepted read, byte is being sent.
   logic reading_next;

   // Shift the header in, then decide whether to answer.
   always_comb begin
      cnt_next = cnt_reg;
      shift_next = shift_reg;
      reading_next = reading_reg;
      if (cnt_reg < HDR_BITS) begin
         shift_next = {shift_reg[30:0], serial_in_pin};
         cnt_next = cnt_reg + CNT_ONE;
         if (cnt_reg == HDR_LAST) begin
            // An array cycle in progress makes the device mute.
            reading_next = (shift_next[CMD_HI:CMD_LO] == READ_LOCK_CMD)
                           && !busy_snap;
         end
      end else begin
         // The byte repeats for as long as the host keeps clocking.
         cnt_next = (cnt_reg == CNT_END) ? HDR_BITS : cnt_reg + CNT_ONE;
      end
   end

   // Frame-end reset: select high clears the link state at once.
   always_ff @(posedge spi_clk or posedge select_n) begin
      if (select_n) begin
         cnt_reg <= '0;
         shift_reg <= '0;
         reading_reg <= 1'b0;
      end else begin
         cnt_reg <= cnt_next;
         shift_reg <= shift_next;
         reading_reg <= reading_next;
      end
   end

   // ==========================================================
   // Lock byte of the addressed sector; low address bits ignored.
   sector_t rd_sec;
   lock_nib_t rd_nib;
   logic [7:0] lock_byte;
   always_comb begin
      rd_sec = shift_reg[SEC_LO +: SEC_W];
      rd_nib = snap_reg[rd_sec];
      lock_byte = BYTE_ZERO;
      lock_byte[WL_BIT] = rd_nib[WL_BIT];
      lock_byte[LD_BIT] = rd_nib[LD_BIT];
      if (LEGACY) begin
         lock_byte[SLD_BIT] = rd_nib[SLD_BIT];
         lock_byte[SWL_BIT] = rd_nib[SWL_BIT] &&
            (rd_sec == SUBSEC_FIRST || rd_sec == SUBSEC_LAST);
      end
   end

   // ==========================================================
   // Link transmit side, on falling serial clock edges.
   logic out_reg;
   logic out_next;
   logic oe_n_reg;
   logic oe_n_next;

   // Present the next bit, most significant first.
   always_comb begin
      out_next = out_reg;
      oe_n_next = oe_n_reg;
      if (reading_reg) begin
         out_next = lock_byte[BIT_MSB - cnt_reg[2:0]];
         oe_n_next = 1'b0;
      end
   end

   // Select high releases the pin immediately.
   always_ff @(negedge spi_clk or posedge select_n) begin
      if (select_n) begin
         out_reg <= 1'b0;
         oe_n_reg <= 1'b1;
      end else begin
         out_reg <= out_next;
         oe_n_reg <= oe_n_next;
      end
   end

   assign serial_out_pin = out_reg;
   assign serial_out_oe_n = oe_n_reg;

   // ==========================================================
   // Checks.
   AST_BIT_ORDER: assert property (
      @(posedge spi_clk) disable iff (select_n)
      reading_reg && !oe_n_reg |->
         out_reg == lock_byte[BIT_MSB - cnt_reg[2:0]])
      else $error("Wrong lock bit on serial output.");
   AST_DRIVE_AFTER_HEADER: assert property (
      @(posedge spi_clk) disable iff (select_n)
      cnt_reg < HDR_BITS |-> oe_n_reg)
      else $error("Output driven before header complete.");
   AST_RELEASE: assert property (
      @(posedge clk) disable iff (!rst_n)
      $past(select_n) && select_n |-> oe_n_reg)
      else $error("Output driven while deselected.");
   AST_BUSY_REJECT: assert property (
      @(posedge spi_clk) disable iff (select_n)
      reading_reg |-> !busy_snap &&
         shift_reg[CMD_HI:CMD_LO] == READ_LOCK_CMD)
      else $error("Read answered while busy or wrong command.");
   AST_RESERVED_ZERO: assert property (
      @(posedge spi_clk) disable iff (select_n)
      reading_reg |-> lock_byte[7:4] == 4'h0 &&
         (LEGACY || lock_byte[3:2] == 2'h0))
      else $error("Reserved lock bits not zero.");
   AST_SUBSEC_SECTORS: assert property (
      @(posedge spi_clk) disable iff (select_n)
      rd_sec != SUBSEC_FIRST && rd_sec != SUBSEC_LAST |->
         !lock_byte[SWL_BIT])
      else $error("Subsector lock shown for wrong sector.");
endmodule : sector_lock_top
`default_nettype wire

// File: spi_host.sv
/*
 Host model: drives serial lock-read frames and collects the answer.
 Assumes the serial clock idles low and runs only inside frames.
*/
`timescale 1ns/1ps
`default_nettype none
module spi_host (
   output logic spi_clk,
   output logic select_n,
   output logic sdo,
   input wire logic sdi,
   input wire logic oe_n,
   output logic [9:0] res,
   output logic done
);
   // ==========================================================
   // Frame driver.
   // Idle state: deselected and the serial clock parked low.
   initial begin
      spi_clk = 1'b0;
      select_n = 1'b1;
      sdo = 1'b0;
      res = 10'h000;
      done = 1'b0;
   end
   // One frame: header, then n sampled output bits, then release.
   // The result is {released, driven, byte left aligned}.
   task automatic frame(input logic [31:0] hdr, input int n);
      #30.7 select_n = 1'b0;
      for (int i = 0; i < 32; i++) begin
         sdo = hdr[31-i];
         #7.5 spi_clk = 1'b1;
         #7.5 spi_clk = 1'b0;
      end
      res = {2'b01, 8'h00};
      for (int i = 0; i < n; i++) begin
         // The input is unused now, so it toggles to expose sloppy decode.
         sdo = ~sdo;
         #7.5 spi_clk = 1'b1;
         if (oe_n !== 1'b0) res[8] = 1'b0;
         res[7-i] = sdi;
         #7.5 spi_clk = 1'b0;
      end
      #3 select_n = 1'b1;
      #5 res[9] = (oe_n === 1'b1) && (sdi === 1'b0);
      done = 1'b1;
      #1 done = 1'b0;
      #25;
   endtask : frame
endmodule : spi_host
`default_nettype wire

// File: tb_top.sv
/*
 Self-checking bench for the lock byte read and the lock store.
 Assumes the host model of spi_host.sv; a legacy and a plain copy of
 the block run side by side and one of them is listened to at a time.
*/
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   import sector_lock_pkg::*;
   // ==========================================================
   // Stimulus signals and design.
   localparam logic [7:0] CMD = 8'h3c; // Arbitrary read command code.
   logic clk = 1'b0;
   logic rstn = 1'b0;
   logic busy = 1'b0;
   logic wr_en = 1'b0;
   sector_t wr_sec = 4'h0;
   logic [7:0] wr_dat = 8'h00;
   sector_t op_sec = 4'h0;
   logic allow_chk = 1'b0;
   logic ce = 1'b1; // Clock enable, dropped once to prove the freeze.
   logic use_base = 1'b0; // Listen to the plain copy instead.
   wire logic spi_clk, select_n, sdo, sdi, oe_n, allowed, host_done;
   wire logic sdi_leg, oe_n_leg, allowed_leg;
   wire logic sdi_base, oe_n_base, allowed_base;
   wire logic [9:0] host_res;
   integer seed = 32'h041f;
   int fails = 0;
   int checked = 0;
   int cyc = 0;
   lock_nib_t lk [NUM_SECTORS]; // Expected lock bits per sector.
   logic [9:0] exp_q [$];
   logic exp_aq [$];
   always #2.5 clk = ~clk;
   sector_lock_top #(.READ_LOCK_CMD(CMD), .LEGACY(1'b1)) uut (
      .clk(clk), .rstn(rstn), .ce(ce), .spi_clk(spi_clk),
      .select_n(select_n), .serial_in_pin(sdo), .serial_out_pin(sdi_leg),
      .serial_out_oe_n(oe_n_leg), .busy(busy), .lock_wr_en(wr_en),
      .lock_wr_sector(wr_sec), .lock_wr_data(wr_dat),
      .op_sector(op_sec), .op_allowed(allowed_leg));
   // The plain copy has no subsector bits; it sees the same traffic.
   sector_lock_top #(.READ_LOCK_CMD(CMD), .LEGACY(1'b0)) uut_base (
      .clk(clk), .rstn(rstn), .ce(ce), .spi_clk(spi_clk),
      .select_n(select_n), .serial_in_pin(sdo), .serial_out_pin(sdi_base),
      .serial_out_oe_n(oe_n_base), .busy(busy), .lock_wr_en(wr_en),
      .lock_wr_sector(wr_sec), .lock_wr_data(wr_dat),
      .op_sector(op_sec), .op_allowed(allowed_base));
   // The selector only moves between frames, while the link is idle.
   assign sdi = use_base ? sdi_base : sdi_leg;
   assign oe_n = use_base ? oe_n_base : oe_n_leg;
   assign allowed = use_base ? allowed_base : allowed_leg;
   spi_host host (.spi_clk(spi_clk), .select_n(select_n), .sdo(sdo),
      .sdi(sdi), .oe_n(oe_n), .res(host_res), .done(host_done));
   // ==========================================================
   // Reporting and comparison.
   task automatic conclude();
      $display("checked %0d fails %0d", checked, fails);
      if (fails == 0 && checked > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask : conclude
   task automatic cmp_byte(input logic [9:0] got, input logic [9:0] exp);
      checked++;
      if (got !== exp) begin
         fails++;
         $display("BAD %0t read %h expected %h", $time, got, exp);
      end
   endtask : cmp_byte
   task automatic cmp_allow(input logic got, input logic exp);
      checked++;
      if (got !== exp) begin
         fails++;
         $display("BAD %0t allow %b expected %b", $time, got, exp);
      end
   endtask : cmp_allow
   // Each finished frame takes the oldest read note off the queue.
   always @(posedge host_done) begin
      cmp_byte(host_res, exp_q.pop_front());
   end
   // Permission is judged mid-cycle, well clear of the launching edge.
   always @(negedge clk) begin
      if (allow_chk) cmp_allow(allowed, exp_aq.pop_front());
   end
   // A hang is cut short by a cycle ceiling far above the run length.
   always @(posedge clk) begin
      cyc++;
      if (cyc == 40000) begin
         fails++;
         conclude();
      end
   end
   // ==========================================================
   // Drivers.
   // Lock write; the model refuses what a set lock-down protects.
   task automatic wr(input sector_t s, input logic [7:0] d);
      @(posedge clk);
      #1 wr_en = 1'b1;
      wr_sec = s;
      wr_dat = d;
      @(posedge clk);
      #1 wr_en = 1'b0;
      if (!lk[s][LD_BIT]) lk[s][1:0] = d[1:0];
      if (!lk[s][SLD_BIT]) begin
         lk[s][SLD_BIT] = d[3];
         lk[s][SWL_BIT] = d[2] & (s == SUBSEC_FIRST || s == SUBSEC_LAST);
      end
   endtask : wr
   // Permission query; the answer is read two edges later.
   task automatic chk(input sector_t s);
      @(posedge clk);
      #1 op_sec = s;
      repeat (2) @(posedge clk);
      #1 exp_aq.push_back(!(lk[s][WL_BIT] |
         (lk[s][SWL_BIT] && !use_base)));
      allow_chk = 1'b1;
      @(posedge clk);
      #1 allow_chk = 1'b0;
   endtask : chk
   // Read frame with random low address bits inside the sector.
   task automatic rd(input logic [7:0] c, input sector_t s, input int n);
      logic [15:0] low;
      logic [7:0] m;
      lock_nib_t nib;
      low = 16'($random(seed));
      m = 8'hff << (8 - n);
      // The plain copy keeps bits 3:2 at zero whatever was written.
      nib = use_base ? (lk[s] & 4'h3) : lk[s];
      if (c == CMD && !busy) exp_q.push_back({2'b11, {4'h0, nib} & m});
      else exp_q.push_back(10'h200);
      host.frame({c, 4'h0, s, low}, n);
   endtask : rd
   task automatic sweep();
      for (int i = 0; i < NUM_SECTORS; i++) begin
         rd(CMD, sector_t'(i), 8);
         chk(sector_t'(i));
      end
   endtask : sweep
   task automatic clear_model();
      for (int i = 0; i < NUM_SECTORS; i++) lk[i] = LOCK_RESET;
   endtask : clear_model
   // ==========================================================
   // Main sequence.
   initial begin
      clear_model();
      repeat (12) @(posedge clk);
      #1 rstn = 1'b1;
      repeat (4) @(posedge clk);
      sweep();
      wr(4'h3, 8'h03);
      wr(4'h3, 8'h00);
      wr(4'h5, 8'h01);
      wr(4'h5, 8'h00);
      wr(4'h0, 8'h0c);
      wr(4'h0, 8'h00);
      wr(4'h7, 8'h04);
      wr(4'hf, 8'h05);
      sweep();
      for (int i = 0; i < 24; i++) begin
         wr(sector_t'($random(seed)), 8'($random(seed)));
      end
      sweep();
      use_base = 1'b1;
      sweep();
      use_base = 1'b0;
      @(posedge clk);
      #1 busy = 1'b1;
      rd(CMD, 4'h3, 8);
      chk(4'h3);
      @(posedge clk);
      #1 busy = 1'b0;
      rd(~CMD, 4'h3, 8);
      rd(CMD, 4'h3, 3);
      rd(CMD, 4'hf, 8);
      // A write offered while the clock enable is low must be lost;
      // flipping both bits makes any leak visible unless locked down.
      @(posedge clk);
      #1 ce = 1'b0;
      wr_en = 1'b1;
      wr_sec = 4'h9;
      wr_dat = {6'h00, ~lk[9][1:0]};
      @(posedge clk);
      #1 wr_en = 1'b0;
      ce = 1'b1;
      rd(CMD, 4'h9, 8);
      chk(4'h9);
      @(posedge clk);
      #1 rstn = 1'b0;
      repeat (3) @(posedge clk);
      #1 rstn = 1'b1;
      clear_model();
      repeat (4) @(posedge clk);
      sweep();
      conclude();
   end
endmodule : tb_top
`default_nettype wire
